// >>> rtl/sso_cfg.svh
`ifndef SSO_CFG_SVH
`define SSO_CFG_SVH
// power-on window, ms
`define SSO_PON_MIN_MS 2500
`define SSO_PON_MAX_MS 3500
// aim at the middle of the window
`define SSO_PON_TGT_MS 3000
`define SSO_CLK_KHZ 100000
// clock cycles in one millisecond equal the clock rate in kHz
`define SSO_MS_CYC (`SSO_CLK_KHZ)
// speed-reached tolerance: 5 percent plus 20
`define SSO_SA_PCT_DIV 20
`define SSO_SA_OFFSET 16'sh0014
`define SSO_SA_LOW_SET 16'sh0014
`define SSO_ZSP_HYST 16'h0014
`define SSO_ZSP_LEVEL_RST 16'h0032
// pin assignment reset values
`define SSO_PIN1_RST 5'h0b
`define SSO_PIN2_RST 5'h01
`define SSO_PIN3_RST 5'h00
// register offsets
`define SSO_REG_CTRL 4'h0
`define SSO_REG_INPR 4'h1
`define SSO_REG_ZSPL 4'h2
`define SSO_REG_BRKD 4'h3
`define SSO_REG_ASGN 4'h4
`define SSO_REG_GPO 4'h5
`define SSO_REG_STAT 4'h6
`endif

// >>> rtl/sso_pkg.sv
package sso_pkg;
	// selectable output devices
	typedef enum logic [4:0] {
		SSO_DEV_MALF = 5'h00,
		SSO_DEV_INPOS = 5'h01,
		SSO_DEV_READY = 5'h02,
		SSO_DEV_SPDR = 5'h03,
		SSO_DEV_WARN = 5'h04,
		SSO_DEV_BWARN = 5'h05,
		SSO_DEV_STOPW = 5'h06,
		SSO_DEV_GAIN1 = 5'h07,
		SSO_DEV_GAIN2 = 5'h08,
		SSO_DEV_ABSL = 5'h09,
		SSO_DEV_RIDE = 5'h0a,
		SSO_DEV_BRAKE = 5'h0b,
		SSO_DEV_CLOOP = 5'h0c,
		SSO_DEV_VLIM = 5'h0d,
		SSO_DEV_ZSP = 5'h0e,
		SSO_DEV_TLIM = 5'h0f,
		SSO_DEV_GPA = 5'h10,
		SSO_DEV_GPB = 5'h11,
		SSO_DEV_GPC = 5'h12
	} sso_dev_t;
	typedef enum logic [1:0] {
		SSO_MODE_POS = 2'h0,
		SSO_MODE_VEL = 2'h1,
		SSO_MODE_TRQ = 2'h2
	} sso_mode_t;
	// drive state sampled from the servo core
	typedef struct packed {
		logic alarm;
		logic base_off;
		logic servo_on;
		logic warning;
		logic batt_cable_warn;
		logic batt_low_warn;
		logic stop_warning;
		logic gain1_en;
		logic gain2_en;
		logic abs_undetermined;
		logic ride_through;
		logic closed_loop;
		logic at_speed_limit;
		logic at_torque_limit;
		sso_mode_t mode;
		logic signed [15:0] speed;
		logic signed [15:0] set_speed;
		logic [15:0] droop;
	} sso_drive_t;
	// decoded flag vector, index = sso_dev_t code
	typedef logic [18:0] sso_flags_t;
endpackage

// >>> rtl/sso_delay.sv
`timescale 1ns/1ps
`include "sso_cfg.svh"
// ----------------------------------------
// off-delay timer stepped by an external ms tick
// ----------------------------------------
module sso_delay #(
	parameter int TW = 16
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic hold_in,
	input wire logic [TW-1:0] delay_ms,
	output logic hold_out
);
	import sso_pkg::*;
	logic [TW-1:0] cnt_r;
	// output follows input on rise, lingers delay_ms ticks on fall
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_r <= '0;
			hold_out <= 1'b0;
		end else if (hold_in) begin
			cnt_r <= delay_ms;
			hold_out <= 1'b1;
		end else if (cnt_r == '0) begin
			hold_out <= 1'b0;
		end else if (tick) begin
			cnt_r <= cnt_r - 1'b1;
		end
	end
endmodule

// >>> rtl/sso_pin_mux.sv
`timescale 1ns/1ps
// ----------------------------------------
// one output pin selector
// ----------------------------------------
module sso_pin_mux (
	input wire logic clock,
	input wire logic rst_n,
	input wire sso_pkg::sso_flags_t flags,
	input wire logic [4:0] sel,
	output logic pin
);
	import sso_pkg::*;
	// unknown codes drive the pin off
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pin <= 1'b0;
		end else if (sel < 5'd19) begin
			pin <= flags[sel];
		end else begin
			pin <= 1'b0;
		end
	end
endmodule

// >>> rtl/sso_top.sv
// The plain strobed port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "sso_cfg.svh"
// Operation
// RULE1: malfunction output off while protection trips and base drive shut off.
// RULE2: with no alarm, malfunction output turns on 2.5 s to 3.5 s after power-on.
// RULE3: in-position on when droop within range; off in velocity and torque modes.
// RULE4: ready output on in servo-on state.
// RULE5: speed reached when speed within set speed plus/minus 5 percent plus 20.
// RULE6: speed reached held on when set speed is 20 or less.
// RULE7: speed reached off at servo-off and in position and torque modes.
// RULE8: warning output on at any warning; else off after power-on window.
// RULE9: battery warning on for cable or low battery warning; else off after window.
// RULE10: motor stop warning on for such warning; else off after window.
// RULE11: gain set flags follow the enabled gain switching sets.
// RULE12: absolute position lost on while absolute position undetermined.
// RULE13: ride-through flag on when enabled and power failure ride-through active.
// RULE14: closed loop flag on while fully closed loop runs.
// RULE15: brake interlock off at servo-off or alarm, with configurable delay. Code drops it at once; brake_delay_r delays only its return.
// RULE16: speed limiting on at speed limit in torque mode, off at servo-off.
// RULE17: zero speed on when speed magnitude at or below level, reset level 50.
// RULE18: zero speed clears only above level plus 20 hysteresis.
// RULE19: torque limiting on at torque limit; off at servo-off and in torque mode.
// RULE20: three general outputs follow the written digital outputs value.
// RULE21: three pins each carry an assigned device; brake, in-position, malfunction.
// RULE22: all flags registered; power-on window counter ends inside the window.
module sso_top #(
	parameter int PON_CYC = `SSO_PON_TGT_MS * `SSO_MS_CYC,
	parameter int MS_CYC = `SSO_MS_CYC
) (
	input wire logic clock,
	input wire logic arst_n,
	input wire sso_pkg::sso_drive_t drive,
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output sso_pkg::sso_flags_t flags,
	output logic [2:0] out_pins
);
	import sso_pkg::*;
	// window bounds scale with the millisecond length in use
	localparam int PON_MIN_CYC = `SSO_PON_MIN_MS * MS_CYC;
	localparam int PON_MAX_CYC = `SSO_PON_MAX_MS * MS_CYC;
	// refuse a power-on count that lands outside the window
	if (MS_CYC < 1 || PON_CYC < PON_MIN_CYC || PON_CYC > PON_MAX_CYC)
	begin : g_bad_count
		$error("sso_top: power-on count outside the window");
	end

	// ----------------------------------------
	// reset release
	// ----------------------------------------
	logic [1:0] rst_sync_r;
	logic rst_n;
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			rst_sync_r <= 2'h0;
		end else begin
			rst_sync_r <= {rst_sync_r[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_r[1];

	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic tough_en_r;
	logic [15:0] inpos_range_r;
	logic [15:0] zsp_level_r;
	logic [15:0] brake_delay_r;
	logic [4:0] pin1_sel_r;
	logic [4:0] pin2_sel_r;
	logic [4:0] pin3_sel_r;
	logic [2:0] gpo_r;
	logic pon_done_r;
	// software writes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			tough_en_r <= 1'b0;
			inpos_range_r <= 16'h0064;
			zsp_level_r <= `SSO_ZSP_LEVEL_RST; // [RULE17]
			brake_delay_r <= 16'h0000;
			pin1_sel_r <= `SSO_PIN1_RST; // [RULE21]
			pin2_sel_r <= `SSO_PIN2_RST;
			pin3_sel_r <= `SSO_PIN3_RST;
			gpo_r <= 3'h0;
		end else if (reg_wr) begin
			unique case (reg_addr)
				`SSO_REG_CTRL: tough_en_r <= reg_wdata[0];
				`SSO_REG_INPR: inpos_range_r <= reg_wdata;
				`SSO_REG_ZSPL: zsp_level_r <= reg_wdata;
				`SSO_REG_BRKD: brake_delay_r <= reg_wdata;
				`SSO_REG_ASGN: begin
					pin1_sel_r <= reg_wdata[4:0];
					pin2_sel_r <= reg_wdata[9:5];
					pin3_sel_r <= reg_wdata[14:10];
				end
				`SSO_REG_GPO: gpo_r <= reg_wdata[2:0]; // [RULE20]
				default: ;
			endcase
		end
	end
	// read data one cycle after the strobe, zero otherwise
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata <= 16'h0000;
		end else if (reg_rd) begin
			unique case (reg_addr)
				`SSO_REG_CTRL: reg_rdata <= {15'h0000, tough_en_r};
				`SSO_REG_INPR: reg_rdata <= inpos_range_r;
				`SSO_REG_ZSPL: reg_rdata <= zsp_level_r;
				`SSO_REG_BRKD: reg_rdata <= brake_delay_r;
				`SSO_REG_ASGN:
					reg_rdata <= {1'b0, pin3_sel_r, pin2_sel_r, pin1_sel_r};
				`SSO_REG_GPO: reg_rdata <= {13'h0000, gpo_r};
				`SSO_REG_STAT: reg_rdata <= {pon_done_r, out_pins, 12'h000};
				default: reg_rdata <= 16'h0000;
			endcase
		end else begin
			reg_rdata <= 16'h0000;
		end
	end

	// ----------------------------------------
	// power-on window and ms tick
	// ----------------------------------------
	logic [31:0] pon_cnt_r;
	logic [31:0] ms_cnt_r;
	logic ms_tick;
	// counts once to PON_CYC after reset release
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pon_cnt_r <= 32'h0;
			pon_done_r <= 1'b0;
		end else if (!pon_done_r) begin
			pon_cnt_r <= pon_cnt_r + 32'h1;
			pon_done_r <= (pon_cnt_r == 32'(PON_CYC - 1)); // [RULE22]
		end
	end
	// millisecond enable for the brake delay
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ms_cnt_r <= 32'h0;
		end else if (ms_tick) begin
			ms_cnt_r <= 32'h0;
		end else begin
			ms_cnt_r <= ms_cnt_r + 32'h1;
		end
	end
	assign ms_tick = (ms_cnt_r == 32'(MS_CYC - 1));

	// ----------------------------------------
	// speed comparisons
	// ----------------------------------------
	logic signed [17:0] spd;
	logic signed [17:0] sset;
	logic signed [17:0] tol;
	logic [16:0] spd_abs;
	logic sa_in_band;
	logic zsp_r;
	assign spd = 18'(drive.speed);
	assign sset = 18'(drive.set_speed);
	// band = |set| / 20 + 20
	assign tol = 18'(((sset < 0) ? -sset : sset) / `SSO_SA_PCT_DIV)
		+ 18'(`SSO_SA_OFFSET);
	assign sa_in_band = (spd >= sset - tol) && (spd <= sset + tol); // [RULE5]
	assign spd_abs = (spd < 0) ? 17'(-spd) : 17'(spd);
	// zero speed with hysteresis
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			zsp_r <= 1'b1;
		end else if (spd_abs <= 17'(zsp_level_r)) begin
			zsp_r <= 1'b1; // [RULE17]
		end else if (spd_abs > 17'(zsp_level_r) + 17'(`SSO_ZSP_HYST)) begin
			zsp_r <= 1'b0; // [RULE18]
		end
	end

	// ----------------------------------------
	// brake interlock delay
	// ----------------------------------------
	logic brake_hold;
	logic brake_ok;
	assign brake_ok = drive.servo_on && !drive.alarm;
	sso_delay #(.TW(16)) u_brake (
		.clock(clock),
		.rst_n(rst_n),
		.tick(ms_tick),
		.hold_in(!brake_ok),
		.delay_ms(brake_delay_r),
		.hold_out(brake_hold)
	);

	// ----------------------------------------
	// flag registers
	// ----------------------------------------
	sso_flags_t fn;
	logic sa_low;
	assign sa_low = (drive.set_speed <= `SSO_SA_LOW_SET)
		&& (drive.set_speed >= -`SSO_SA_LOW_SET);
	// next flag vector from drive state
	always_comb begin
		fn = '0;
		fn[SSO_DEV_MALF] = pon_done_r && !drive.alarm
			&& !drive.base_off; // [RULE1] [RULE2]
		fn[SSO_DEV_INPOS] = (drive.mode == SSO_MODE_POS)
			&& (drive.droop <= inpos_range_r); // [RULE3]
		fn[SSO_DEV_READY] = drive.servo_on; // [RULE4]
		fn[SSO_DEV_SPDR] = drive.servo_on && (drive.mode == SSO_MODE_VEL)
			&& (sa_low || sa_in_band); // [RULE6] [RULE7]
		fn[SSO_DEV_WARN] = drive.warning || !pon_done_r; // [RULE8]
		fn[SSO_DEV_BWARN] = drive.batt_cable_warn || drive.batt_low_warn
			|| !pon_done_r; // [RULE9]
		fn[SSO_DEV_STOPW] = drive.stop_warning || !pon_done_r; // [RULE10]
		fn[SSO_DEV_GAIN1] = drive.gain1_en; // [RULE11]
		fn[SSO_DEV_GAIN2] = drive.gain2_en;
		fn[SSO_DEV_ABSL] = drive.abs_undetermined; // [RULE12]
		fn[SSO_DEV_RIDE] = tough_en_r && drive.ride_through; // [RULE13]
		// drops at once on servo-off or alarm, no reset glitch
		fn[SSO_DEV_BRAKE] = brake_ok && !brake_hold; // [RULE15]
		fn[SSO_DEV_CLOOP] = drive.closed_loop; // [RULE14]
		fn[SSO_DEV_VLIM] = drive.servo_on && (drive.mode == SSO_MODE_TRQ)
			&& drive.at_speed_limit; // [RULE16]
		fn[SSO_DEV_ZSP] = zsp_r;
		fn[SSO_DEV_TLIM] = drive.servo_on && (drive.mode != SSO_MODE_TRQ)
			&& drive.at_torque_limit; // [RULE19]
		fn[SSO_DEV_GPA] = gpo_r[0];
		fn[SSO_DEV_GPB] = gpo_r[1];
		fn[SSO_DEV_GPC] = gpo_r[2];
	end
	// warnings read as on until the window closes
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			flags <= 19'h00070;
		end else begin
			flags <= fn; // [RULE22]
		end
	end

	// ----------------------------------------
	// output pins
	// ----------------------------------------
	logic [4:0] pin_sel [3];
	assign pin_sel[0] = pin1_sel_r;
	assign pin_sel[1] = pin2_sel_r;
	assign pin_sel[2] = pin3_sel_r;
	for (genvar i = 0; i < 3; i++) begin : g_pin
		sso_pin_mux u_mux (
			.clock(clock),
			.rst_n(rst_n),
			.flags(flags),
			.sel(pin_sel[i]),
			.pin(out_pins[i]) // [RULE21]
		);
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_malf_alarm_off: assert property (@(posedge clock) disable iff (!rst_n)
		drive.alarm && drive.base_off |=> !flags[SSO_DEV_MALF]) // [RULE1]
		else $error("malfunction output on during trip");
	a_malf_early_off: assert property (@(posedge clock) disable iff (!rst_n)
		(pon_cnt_r < 32'(PON_MIN_CYC)) && !pon_done_r
		|-> !flags[SSO_DEV_MALF]) // [RULE2]
		else $error("malfunction output on too early");
	a_pon_window: assert property (@(posedge clock) disable iff (!rst_n)
		$rose(pon_done_r) |-> (pon_cnt_r >= 32'(PON_MIN_CYC - 1))
		&& (pon_cnt_r <= 32'(PON_MAX_CYC))) // [RULE22]
		else $error("power-on window out of range");
	a_ready_follow: assert property (@(posedge clock) disable iff (!rst_n)
		drive.servo_on |=> flags[SSO_DEV_READY]) // [RULE4]
		else $error("ready output not following servo-on");
	a_inpos_mode: assert property (@(posedge clock) disable iff (!rst_n)
		drive.mode != SSO_MODE_POS |=> !flags[SSO_DEV_INPOS]) // [RULE3]
		else $error("in-position on outside position mode");
	a_sa_servo_off: assert property (@(posedge clock) disable iff (!rst_n)
		!drive.servo_on |=> !flags[SSO_DEV_SPDR]) // [RULE7]
		else $error("speed reached on at servo-off");
	a_zsp_hyst: assert property (@(posedge clock) disable iff (!rst_n)
		zsp_r && spd_abs <= 17'(zsp_level_r) + 17'(`SSO_ZSP_HYST)
		|=> zsp_r) // [RULE18]
		else $error("zero speed cleared inside hysteresis");
	a_tlc_torque: assert property (@(posedge clock) disable iff (!rst_n)
		drive.mode == SSO_MODE_TRQ |=> !flags[SSO_DEV_TLIM]) // [RULE19]
		else $error("torque limiting on in torque mode");
	a_brake_alarm: assert property (@(posedge clock) disable iff (!rst_n)
		drive.alarm || !drive.servo_on |=> !flags[SSO_DEV_BRAKE]) // [RULE15]
		else $error("brake interlock on during alarm or servo-off");
	a_warn_any: assert property (@(posedge clock) disable iff (!rst_n)
		drive.warning |=> flags[SSO_DEV_WARN]) // [RULE8]
		else $error("warning output missing");
endmodule

// >>> bench/sso_relay_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// relay bank on the three output pins
// ----------------------------------------
module sso_relay_model (
	input wire logic clock,
	input wire logic [2:0] coil,
	output logic [2:0] contact
);
	// contacts follow their coils one clock late
	always_ff @(posedge clock) begin
		contact <= coil;
	end
endmodule

// >>> bench/tb.sv
`timescale 1ns/1ps
`include "sso_cfg.svh"
module tb;
	import sso_pkg::*;
	typedef struct packed {
		logic [13:0] b;
		sso_mode_t md;
		logic [15:0] sp;
		logic [15:0] st;
		logic [15:0] dr;
		sso_flags_t m;
		sso_flags_t e;
	} sso_row_t;
	localparam sso_mode_t P = SSO_MODE_POS;
	localparam sso_mode_t V = SSO_MODE_VEL;
	localparam sso_mode_t T = SSO_MODE_TRQ;
	localparam sso_flags_t M = 19'h0bfff;
	logic clock = 1'b0;
	logic arst_n = 1'b0;
	sso_drive_t drive = '0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [15:0] d;
	sso_flags_t flags;
	logic [2:0] out_pins;
	logic [2:0] contact;
	sso_row_t rows [19];
	sso_row_t r;
	logic [15:0] rst_exp [7];
	logic [15:0] zs [8];
	logic [7:0] ze = 8'h66;
	int n_mismatch = 0;
	int samples_checked = 0;
	// ----------------------------------------
	// clock, design and far side
	// ----------------------------------------
	always #5 clock = ~clock;
	sso_top #(.PON_CYC(12000), .MS_CYC(4)) DUT (.clock(clock),
		.arst_n(arst_n), .drive(drive), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .flags(flags), .out_pins(out_pins));
	sso_relay_model relays (.clock(clock), .coil(out_pins),
		.contact(contact));
	// ----------------------------------------
	// compare, bus and closing tasks
	// ----------------------------------------
	task automatic chk_reg(input string nm, input logic [15:0] e);
		samples_checked++;
		if (d !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, d);
		end
	endtask
	task automatic chk_flg(input string nm, input sso_flags_t m,
		input sso_flags_t e);
		samples_checked++;
		if ((flags & m) !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %h seen %h", nm, e, flags & m);
		end
	endtask
	task automatic chk_pin(input string nm, input logic [2:0] e);
		samples_checked++;
		if (contact !== e) begin
			n_mismatch++;
			$display("MISMATCH %s expected %b seen %b", nm, e, contact);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// apply one drive state and let flags, pins and relays settle
	task automatic put(input sso_row_t x);
		@(posedge clock);
		drive <= {x.b, x.md, x.sp, x.st, x.dr};
		repeat (5) @(posedge clock);
		#1;
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// watchdog: the whole run needs about 12300 cycles
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		$display("watchdog expired");
		wrap_up();
	end
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		rows = '{'{14'h0800, V, 16'h03e8, 16'h03e8, 16'h0, M, 19'h0080d},
			'{14'h0800, V, 16'h042e, 16'h03e8, 16'h0, M, 19'h0080d},
			'{14'h0800, V, 16'h03a2, 16'h03e8, 16'h0, M, 19'h0080d},
			'{14'h0800, V, 16'h042f, 16'h03e8, 16'h0, M, 19'h00805},
			'{14'h0800, V, 16'h01f4, 16'h0014, 16'h0, M, 19'h0080d},
			'{14'h0800, V, 16'h01f4, 16'h0015, 16'h0, M, 19'h00805},
			'{14'h0000, V, 16'h03e8, 16'h03e8, 16'h0, M, 19'h00001},
			'{14'h0800, P, 16'h0, 16'h0, 16'h0032, M, 19'h00807},
			'{14'h0800, P, 16'h0, 16'h0, 16'h00c8, M, 19'h00805},
			'{14'h0800, V, 16'h0, 16'h0, 16'h0032, M, 19'h0080d},
			'{14'h0803, T, 16'h0, 16'h0, 16'h0, M, 19'h02805},
			'{14'h0803, P, 16'h0, 16'h0, 16'h0, M, 19'h08807},
			'{14'h0003, T, 16'h0, 16'h0, 16'h0, M, 19'h00001},
			'{14'h0003, P, 16'h0, 16'h0, 16'h0, 19'h0bffd, 19'h00001},
			'{14'h2800, V, 16'h0, 16'h0, 16'h0, 19'h00801, 19'h0},
			'{14'h1000, V, 16'h0, 16'h0, 16'h0, 19'h00001, 19'h0},
			'{14'h04fc, V, 16'h0, 16'h0, 16'h0, M, 19'h013d1},
			'{14'h0200, V, 16'h0, 16'h0, 16'h0, 19'h0bfef, 19'h00021},
			'{14'h0100, V, 16'h0, 16'h0, 16'h0, 19'h0bfef, 19'h00021}};
		rst_exp = '{16'h0, 16'h0064, 16'h0032, 16'h0, 16'h002b, 16'h0, 16'h0};
		zs = '{16'h0064, 16'h0032, 16'h0046, 16'h0047, 16'h0033, 16'h0032,
			16'hffba, 16'hffb9};
		repeat (8) @(posedge clock);
		arst_n <= 1'b1;
		repeat (3) @(posedge clock);
		// reset values, the last index is unmapped
		for (int i = 0; i < 7; i++) begin
			rd((i == 6) ? 4'hf : 4'(i));
			chk_reg("reg_reset", rst_exp[i]);
		end
		chk_flg("flags_reset", 19'h00071, 19'h00070);
		$display("reset test done");
		repeat (9900) @(posedge clock);
		#1;
		chk_flg("flags_early", 19'h00071, 19'h00070);
		repeat (2100) @(posedge clock);
		#1;
		chk_flg("flags_pon", 19'h00071, 19'h00001);
		rd(`SSO_REG_STAT);
		d = d & 16'h8000;
		chk_reg("stat_pon", 16'h8000);
		$display("power-on test done");
		foreach (rows[i]) begin
			put(rows[i]);
			chk_flg("flags_row", rows[i].m, rows[i].e);
		end
		$display("row test done");
		r = rows[6];
		r.b = 14'h0008;
		put(r);
		chk_flg("ride_off", 19'h00400, 19'h0);
		wr(`SSO_REG_CTRL, 16'h0001);
		put(r);
		chk_flg("ride_on", 19'h00400, 19'h00400);
		$display("ride-through test done");
		r = rows[6];
		for (int i = 0; i < 8; i++) begin
			r.sp = zs[i];
			put(r);
			chk_flg("zero_speed", 19'h04000, 19'(ze[i]) << 14);
		end
		$display("zero speed test done");
		put(rows[7]);
		chk_pin("pins_default", 3'b111);
		put(rows[8]);
		chk_pin("pins_default", 3'b101);
		wr(`SSO_REG_ASGN, 16'h4e02);
		wr(`SSO_REG_GPO, 16'h0001);
		put(rows[0]);
		chk_pin("pins_assigned", 3'b011);
		wr(`SSO_REG_GPO, 16'h0006);
		put(rows[0]);
		chk_flg("general_out", 19'h70000, 19'h60000);
		chk_pin("pins_assigned", 3'b001);
		rd(`SSO_REG_GPO);
		chk_reg("gpo_read", 16'h0006);
		$display("pin test done");
		wr(`SSO_REG_BRKD, 16'h0005);
		put(rows[7]);
		put(rows[6]);
		chk_flg("brake_drop", 19'h00800, 19'h0);
		put(rows[7]);
		chk_flg("brake_hold", 19'h00800, 19'h0);
		repeat (25) @(posedge clock);
		#1;
		chk_flg("brake_release", 19'h00800, 19'h00800);
		$display("brake delay test done");
		wrap_up();
	end
endmodule
